// *** edh_core.v ***
// EDH check core: crc, checksum, flags, errored-field counter, flag port
// assumes a parsed stream: word strobes and region/packet markers from the
// framer on i_clk; flag port pins are asynchronous and are synchronised
// Summary of operation
// - crc both streams, compare in, insert out
// - host reads received and outgoing crcs
// - compare crc only when validity high
// - invalid region: edh clear unless illegal checksum with fix on, eda=or, valid
// - receive mode ues = ues in or invalid
// - missing packet sets all three ues in receive mode
// - outgoing validity high unless overwritten
// - anc checksum mismatch raises anc edh in receive mode
// - fix pin or bit replaces anc checksum
// - in receive mode, illegal checksum 3FC-3FF sets ff and ap edh when fix on
// - written anc flags replace checksum result
// - packet checksum error sets packet_sum_err
// - packet_absent unless header found in place
// - 24-bit counter counts errored outgoing packets
// - sensitivity low enables; sum bit high enables
// - mode 01 clears then returns to 00
// - mode 10 clears on low byte read
// - mode 11 holds counter at zero
// - port writes hit next packet, beat host
// - select picks ff, ap, anc or control
// - read source latched, reset low
// - read drives selected group, control layout
// - read data three clocks after select pins (two sync flops, one output flop)
`timescale 1ns/1ns
module edh_core #(
    parameter CNT_W = 24
) (
    input  wire        i_clk,
    input  wire        i_rst,
    input  wire        i_rx_mode,
    input  wire        i_anc_sum_fix_en,
    input  wire [9:0]  i_in_data,
    input  wire        i_in_word,
    input  wire [9:0]  i_out_data,
    input  wire        i_out_word,
    input  wire        i_field_start,
    input  wire        i_ff_region,
    input  wire        i_ap_region,
    input  wire        i_anc_sum_word,
    input  wire [9:0]  i_anc_sum_calc,
    input  wire        i_pkt_hdr_ok,
    input  wire        i_pkt_in_place,
    input  wire        i_pkt_done,
    input  wire        i_pkt_sum_bad,
    input  wire [15:0] i_rx_ff_crc,
    input  wire [15:0] i_rx_ap_crc,
    input  wire        i_rx_ffv,
    input  wire        i_rx_apv,
    input  wire [14:0] i_rx_flags,
    input  wire        i_out_pkt,
    input  wire        i_flag_dir,
    input  wire [1:0]  i_flag_sel,
    input  wire [4:0]  i_flag_lines,
    input  wire [7:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    output reg  [9:0]  o_anc_sum,
    output reg         o_anc_sum_replace,
    output reg  [15:0] o_tx_ff_crc,
    output reg  [15:0] o_tx_ap_crc,
    output reg         o_tx_ffv,
    output reg         o_tx_apv,
    output reg  [14:0] o_tx_flags,
    output reg         o_packet_absent,
    output reg         o_packet_sum_err,
    output reg  [4:0]  o_flag_lines,
    output reg         o_flag_lines_oe
);
`include "edh_map.vh"
    // flag word layout per region: {ues, ida, idh, eda, edh}
    function [4:0] grp;
        input [14:0] f;
        input [1:0]  s;
        begin
            case (s)
                `EDH_SEL_FF: grp = f[4:0];
                `EDH_SEL_AP: grp = f[9:5];
                default:     grp = f[14:10];
            endcase
        end
    endfunction
    function [4:0] region;
        input [4:0] in;
        input       v;
        input       crc_bad;
        input       anc_bad;
        input       rx;
        input       absent;
        reg   [4:0] r;
        begin
            r[4] = rx & (in[4] | ~v | absent);
            r[3] = in[3] | in[2];
            r[2] = in[1];
            r[1] = in[0] | in[1];
            r[0] = v & crc_bad | anc_bad;
            region = r;
        end
    endfunction
    wire [15:0] in_ff_crc;
    wire [15:0] in_ap_crc;
    wire [15:0] out_ff_crc;
    wire [15:0] out_ap_crc;
    reg  [1:0]  dir_s;
    reg  [3:0]  sel_s;
    reg  [9:0]  lines_s;
    reg  [31:0] ctrl;
    reg  [15:0] sens;
    reg  [16:0] ovr_val;
    reg  [16:0] ovr_ctl;
    reg  [16:0] port_val;
    reg  [16:0] port_ctl;
    reg         read_src;
    reg         anc_err;
    reg         illegal_sum;
    reg         seen;
    reg  [14:0] in_flags;
    reg         in_ffv;
    reg         in_apv;
    reg  [15:0] in_ff_rx;
    reg  [15:0] in_ap_rx;
    reg  [CNT_W-1:0] cnt;
    reg         low_read;
    reg  [14:0] next_flags;
    reg         next_ffv;
    reg         next_apv;
    reg  [4:0]  next_lines;
    wire        fix_on = i_anc_sum_fix_en | ctrl[`EDH_CTRL_FIX_BIT];
    wire [1:0]  mode = ctrl[`EDH_CTRL_MODE_LSB+1:`EDH_CTRL_MODE_LSB];
    edh_crc16 u_in_ff (.i_clk(i_clk), .i_rst(i_rst), .i_clr(i_field_start),
        .i_en(i_in_word & i_ff_region), .i_data(i_in_data),
        .o_crc(in_ff_crc));
    edh_crc16 u_in_ap (.i_clk(i_clk), .i_rst(i_rst), .i_clr(i_field_start),
        .i_en(i_in_word & i_ap_region), .i_data(i_in_data),
        .o_crc(in_ap_crc));
    edh_crc16 u_out_ff (.i_clk(i_clk), .i_rst(i_rst), .i_clr(i_field_start),
        .i_en(i_out_word & i_ff_region), .i_data(i_out_data),
        .o_crc(out_ff_crc));
    edh_crc16 u_out_ap (.i_clk(i_clk), .i_rst(i_rst), .i_clr(i_field_start),
        .i_en(i_out_word & i_ap_region), .i_data(i_out_data),
        .o_crc(out_ap_crc));
    // pins arrive from another chip: two flops before any use
    always @(posedge i_clk) begin
        if (i_rst) begin
            dir_s   <= 2'h3;
            sel_s   <= 4'h0;
            lines_s <= 10'h000;
        end else begin
            dir_s   <= {dir_s[0], i_flag_dir};
            sel_s   <= {sel_s[1:0], i_flag_sel};
            lines_s <= {lines_s[4:0], i_flag_lines};
        end
    end
    // outgoing flag merge: port writes beat host overwrites
    always @* begin
        next_flags[4:0]   = region(i_rx_flags[4:0], i_rx_ffv,
            in_ff_crc != i_rx_ff_crc, illegal_sum & fix_on, i_rx_mode,
            ~seen);
        next_flags[9:5]   = region(i_rx_flags[9:5], i_rx_apv,
            in_ap_crc != i_rx_ap_crc, illegal_sum & fix_on, i_rx_mode,
            ~seen);
        next_flags[14:10] = region(i_rx_flags[14:10], 1'b1, 1'b0,
            anc_err, i_rx_mode, ~seen);
        if (!i_rx_mode)
            next_flags = 15'h0000;
        next_ffv = 1'b1;
        next_apv = 1'b1;
        next_flags = (next_flags & ~ovr_ctl[14:0]) | (ovr_val[14:0]
            & ovr_ctl[14:0]);
        next_flags = (next_flags & ~port_ctl[14:0]) | (port_val[14:0]
            & port_ctl[14:0]);
        if (ovr_ctl[15])
            next_apv = ovr_val[15];
        if (ovr_ctl[16])
            next_ffv = ovr_val[16];
        if (port_ctl[15])
            next_apv = port_val[15];
        if (port_ctl[16])
            next_ffv = port_val[16];
    end
    // field-level checking and packet insertion
    always @(posedge i_clk) begin
        if (i_rst) begin
            anc_err           <= 1'b0;
            illegal_sum       <= 1'b0;
            seen              <= 1'b0;
            o_anc_sum         <= 10'h000;
            o_anc_sum_replace <= 1'b0;
            o_tx_flags        <= 15'h0000;
            o_tx_ffv          <= 1'b1;
            o_tx_apv          <= 1'b1;
            o_tx_ff_crc       <= 16'h0000;
            o_tx_ap_crc       <= 16'h0000;
            o_packet_absent   <= 1'b0;
            o_packet_sum_err  <= 1'b0;
            in_flags          <= 15'h0000;
            in_ffv            <= 1'b0;
            in_apv            <= 1'b0;
            in_ff_rx          <= 16'h0000;
            in_ap_rx          <= 16'h0000;
        end else begin
            o_anc_sum         <= i_anc_sum_calc;
            o_anc_sum_replace <= i_anc_sum_word & fix_on;
            if (i_field_start) begin
                anc_err     <= 1'b0;
                illegal_sum <= 1'b0;
            end
            if (i_anc_sum_word) begin
                if (i_in_data[8:0] != i_anc_sum_calc[8:0])
                    anc_err <= 1'b1;
                if (i_in_data >= `EDH_SUM_ILLEGAL)
                    illegal_sum <= 1'b1;
            end
            if (i_pkt_done) begin
                seen             <= i_pkt_hdr_ok & i_pkt_in_place;
                o_packet_absent  <= ~(i_pkt_hdr_ok & i_pkt_in_place);
                o_packet_sum_err <= i_pkt_sum_bad;
                in_flags         <= i_rx_flags;
                in_ffv           <= i_rx_ffv;
                in_apv           <= i_rx_apv;
                in_ff_rx         <= i_rx_ff_crc;
                in_ap_rx         <= i_rx_ap_crc;
            end else if (i_field_start && !seen) begin
                o_packet_absent <= 1'b1;
            end
            if (i_out_pkt) begin
                o_tx_flags  <= next_flags;
                o_tx_ffv    <= next_ffv;
                o_tx_apv    <= next_apv;
                o_tx_ff_crc <= out_ff_crc;
                o_tx_ap_crc <= out_ap_crc;
                if (!i_pkt_done)
                    seen <= 1'b0;
            end
        end
    end
    // flag port: group and validity writes hold until the next outgoing packet only; read_src stays latched
    always @(posedge i_clk) begin
        if (i_rst) begin
            port_val <= 17'h00000;
            port_ctl <= 17'h00000;
            read_src <= 1'b0;
        end else begin
            if (i_out_pkt)
                port_ctl <= 17'h00000;
            if (!dir_s[1]) begin
                case (sel_s[3:2])
                    `EDH_SEL_FF: begin
                        port_val[4:0] <= lines_s[9:5];
                        port_ctl[4:0] <= 5'h1F;
                    end
                    `EDH_SEL_AP: begin
                        port_val[9:5] <= lines_s[9:5];
                        port_ctl[9:5] <= 5'h1F;
                    end
                    `EDH_SEL_ANC: begin
                        port_val[14:10] <= lines_s[9:5];
                        port_ctl[14:10] <= 5'h1F;
                    end
                    default: begin
                        read_src        <= lines_s[9];
                        port_val[15]    <= lines_s[8];
                        port_val[16]    <= lines_s[7];
                        port_ctl[16:15] <= 2'h3;
                    end
                endcase
            end
        end
    end
    // read side: data one clock after the select is taken
    always @* begin
        case (sel_s[3:2])
            `EDH_SEL_CTL:
                next_lines = {o_packet_sum_err & ~read_src,
                    in_apv & read_src, in_ffv & read_src,
                    sel_s[3:2]};
            default:
                next_lines = read_src ? grp(in_flags, sel_s[3:2])
                    : grp(o_tx_flags, sel_s[3:2]);
        endcase
    end

    always @(posedge i_clk) begin
        if (i_rst) begin
            o_flag_lines    <= 5'h00;
            o_flag_lines_oe <= 1'b0;
        end else begin
            o_flag_lines_oe <= dir_s[1];
            o_flag_lines    <= next_lines;
        end
    end

    // errored-field counter
    always @(posedge i_clk) begin
        if (i_rst) begin
            cnt <= {CNT_W{1'b0}};
        end else if (mode == `EDH_MODE_HOLD || mode == `EDH_MODE_CLEAR
                     || (mode == `EDH_MODE_AUTO && low_read)) begin
            cnt <= {CNT_W{1'b0}};
        end else if (i_out_pkt && ((|(next_flags & ~sens[14:0]))
                     || (sens[15] && o_packet_sum_err))) begin
            cnt <= cnt + 1'b1;
        end
    end

    // avalon slave: one wait cycle per access, then answer
    always @(posedge i_clk) begin
        if (i_rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
            ctrl            <= `EDH_CTRL_RESET;
            sens            <= `EDH_SENS_RESET;
            ovr_val         <= 17'h00000;
            ovr_ctl         <= 17'h00000;
            low_read        <= 1'b0;
        end else begin
            low_read        <= 1'b0;
            avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
            if (mode == `EDH_MODE_CLEAR)
                ctrl[2:1] <= `EDH_MODE_NORMAL;
            if (avs_write && avs_waitrequest) begin
                case (avs_address)
                    `EDH_REG_CTRL:    ctrl    <= avs_writedata;
                    `EDH_REG_SENS:    sens    <= avs_writedata[15:0];
                    `EDH_REG_OVR_VAL: ovr_val <= avs_writedata[16:0];
                    `EDH_REG_OVR_CTL: ovr_ctl <= avs_writedata[16:0];
                    default: ;
                endcase
            end
            if (avs_read && avs_waitrequest) begin
                case (avs_address)
                    `EDH_REG_CTRL:      avs_readdata <= ctrl;
                    `EDH_REG_SENS:      avs_readdata <= {16'h0000, sens};
                    `EDH_REG_OVR_VAL:   avs_readdata <= {15'h0000, ovr_val};
                    `EDH_REG_OVR_CTL:   avs_readdata <= {15'h0000, ovr_ctl};
                    `EDH_REG_STATUS:    avs_readdata <= {27'h0000000,
                        in_ffv, in_apv, read_src, o_packet_absent,
                        o_packet_sum_err};
                    `EDH_REG_IN_FLAGS:  avs_readdata <= {17'h00000, in_flags};
                    `EDH_REG_OUT_FLAGS: avs_readdata <= {15'h0000,
                        o_tx_ffv, o_tx_apv, o_tx_flags};
                    `EDH_REG_IN_FF_CRC: avs_readdata <= {16'h0000,
                        in_ff_rx};
                    `EDH_REG_IN_AP_CRC: avs_readdata <= {16'h0000,
                        in_ap_rx};
                    `EDH_REG_OUT_FF_CRC: avs_readdata <= {16'h0000,
                        o_tx_ff_crc};
                    `EDH_REG_OUT_AP_CRC: avs_readdata <= {16'h0000,
                        o_tx_ap_crc};
                    `EDH_REG_CNT:       avs_readdata <= {8'h00, cnt};
                    `EDH_REG_CNT_LOW: begin
                        avs_readdata <= {24'h000000, cnt[7:0]};
                        low_read     <= 1'b1;
                    end
                    default:            avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule

// *** edh_map.vh ***
// register offsets, field positions, reset values and codes for the EDH core
// assumes a 32-bit Avalon-MM slave with byte addresses, one word per register
`ifndef EDH_MAP_VH
`define EDH_MAP_VH
`define EDH_REG_CTRL      8'h00
`define EDH_REG_SENS      8'h04
`define EDH_REG_OVR_VAL   8'h08
`define EDH_REG_OVR_CTL   8'h0C
`define EDH_REG_STATUS    8'h10
`define EDH_REG_IN_FLAGS  8'h14
`define EDH_REG_OUT_FLAGS 8'h18
`define EDH_REG_IN_FF_CRC 8'h1C
`define EDH_REG_IN_AP_CRC 8'h20
`define EDH_REG_OUT_FF_CRC 8'h24
`define EDH_REG_OUT_AP_CRC 8'h28
`define EDH_REG_CNT       8'h2C
`define EDH_REG_CNT_LOW   8'h30
`define EDH_IDX_CNT_LOW   8'h17
`define EDH_CTRL_FIX_BIT  0
`define EDH_CTRL_MODE_LSB 1
`define EDH_CTRL_RESET    32'h0000_0000
`define EDH_SENS_RESET    16'hFFFF
`define EDH_MODE_NORMAL   2'h0
`define EDH_MODE_CLEAR    2'h1
`define EDH_MODE_AUTO     2'h2
`define EDH_MODE_HOLD     2'h3
`define EDH_SEL_FF        2'h0
`define EDH_SEL_AP        2'h1
`define EDH_SEL_ANC       2'h2
`define EDH_SEL_CTL       2'h3
`define EDH_ADF0          10'h000
`define EDH_ADF1          10'h3FF
`define EDH_DID           10'h1F4
`define EDH_SUM_ILLEGAL   10'h3FC
`define EDH_CRC_POLY      16'h1021
`endif

// *** edh_crc16.v ***
// crc16 accumulator for one region of the picture
// assumes i_clr and i_en come from logic on the same clock
`timescale 1ns/1ns
module edh_crc16 (
    input  wire        i_clk,
    input  wire        i_rst,
    input  wire        i_clr,
    input  wire        i_en,
    input  wire [9:0]  i_data,
    output reg  [15:0] o_crc
);
`include "edh_map.vh"
    // bit-serial over the ten data bits, msb first
    function [15:0] step;
        input [15:0] c;
        input [9:0]  d;
        integer      k;
        reg   [15:0] t;
        begin
            t = c;
            for (k = 9; k >= 0; k = k - 1) begin
                if (t[15] ^ d[k])
                    t = {t[14:0], 1'b0} ^ `EDH_CRC_POLY;
                else
                    t = {t[14:0], 1'b0};
            end
            step = t;
        end
    endfunction

    always @(posedge i_clk) begin
        if (i_rst || i_clr)
            o_crc <= 16'h0000;
        else if (i_en)
            o_crc <= step(o_crc, i_data);
    end
endmodule

// *** edh_core_assertions.sv ***
// checker for edh_core: flag port, bus answer and packet status timing
// assumes it is bound to edh_core and sees only its ports
`timescale 1ns/1ns
module edh_chk #(
    parameter CNT_W = 24
) (
    input wire        i_clk,
    input wire        i_rst,
    input wire        i_anc_sum_word,
    input wire        i_anc_sum_fix_en,
    input wire [9:0]  i_anc_sum_calc,
    input wire        i_pkt_done,
    input wire        i_pkt_hdr_ok,
    input wire        i_pkt_in_place,
    input wire        i_pkt_sum_bad,
    input wire        i_out_pkt,
    input wire        i_flag_dir,
    input wire        avs_waitrequest,
    input wire [9:0]  o_anc_sum,
    input wire        o_anc_sum_replace,
    input wire        o_tx_ffv,
    input wire        o_tx_apv,
    input wire [14:0] o_tx_flags,
    input wire        o_packet_absent,
    input wire        o_packet_sum_err,
    input wire        o_flag_lines_oe
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    AST_OE_READ: assert property (
        i_flag_dir [*4] |-> o_flag_lines_oe)
        else $error("flag lines not driven in read mode");
    AST_OE_WRITE: assert property (
        !i_flag_dir [*4] |-> !o_flag_lines_oe)
        else $error("flag lines driven in write mode");
    AST_TXF_PKT: assert property (
        $changed(o_tx_flags) |-> $past(i_out_pkt))
        else $error("outgoing flags moved outside a packet");
    AST_TXV_PKT: assert property (
        $changed({o_tx_ffv, o_tx_apv}) |-> $past(i_out_pkt))
        else $error("outgoing validity moved outside a packet");
    AST_WAIT_ONE: assert property (
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low longer than one cycle");
    AST_SUM_ERR: assert property (
        i_pkt_done && i_pkt_sum_bad |=> o_packet_sum_err)
        else $error("bad packet checksum not flagged");
    AST_ABSENT: assert property (
        i_pkt_done && !(i_pkt_hdr_ok && i_pkt_in_place)
        |=> o_packet_absent)
        else $error("missing packet not flagged");
    AST_ANC_FIX: assert property (
        i_anc_sum_word && i_anc_sum_fix_en |=> o_anc_sum_replace
        && o_anc_sum == $past(i_anc_sum_calc))
        else $error("checksum not replaced with pin high");
endmodule
bind edh_core edh_chk #(.CNT_W(CNT_W)) u_chk (.*);

// *** edh_flag_ctl.sv ***
// flag port controller model: writes and reads flag groups on the pins
// assumes the core resynchronises the pins on the same clock
`timescale 1ns/1ns
module edh_flag_ctl (
    input  wire       i_clk,
    input  wire [4:0] i_wire,
    output reg        o_dir,
    output reg  [1:0] o_sel,
    output wire [4:0] o_lines,
    output reg        o_lines_oe
);
    reg [4:0] val;
    reg [4:0] pat;
    // released lines toggle so a stale value never reads as valid
    assign o_lines = o_lines_oe ? val : pat;
    initial begin
        o_dir      = 1'b1;
        o_sel      = 2'h0;
        o_lines_oe = 1'b0;
        val        = 5'h00;
        pat        = 5'h15;
    end
    always @(posedge i_clk) begin
        pat <= ~pat;
    end
    task put(input [1:0] s, input [4:0] v);
        begin
            o_dir <= 1'b0;
            o_sel <= s;
            repeat (3) @(posedge i_clk);
            val        <= v;   // core lets go only after its synced dir
            o_lines_oe <= 1'b1;
            repeat (4) @(posedge i_clk);
        end
    endtask
    task done_wr;
        begin
            o_dir <= 1'b1;
            @(posedge i_clk);
            o_lines_oe <= 1'b0;
            repeat (4) @(posedge i_clk);
        end
    endtask
    task get(input [1:0] s, output [4:0] v);
        begin
            o_sel <= s;
            repeat (4) @(posedge i_clk);
            v = i_wire;
        end
    endtask
endmodule

// *** tb.sv ***
// bench for edh_core: bus reads checked through a queue, flag port
// through the controller model; assumes transmit mode unless set
`timescale 1ns/1ns
`include "edh_map.vh"
module tb;
    reg         i_clk, i_rst, i_rx_mode, i_anc_sum_fix_en, anc_go;
    reg         i_in_word, i_out_word, i_field_start, i_ff_region;
    reg         i_ap_region, i_anc_sum_word, i_pkt_hdr_ok, i_pkt_in_place;
    reg         i_pkt_done, i_pkt_sum_bad, i_rx_ffv, i_rx_apv, i_out_pkt;
    reg  [9:0]  i_in_data, i_out_data, i_anc_sum_calc;
    reg  [15:0] i_rx_ff_crc, i_rx_ap_crc;
    reg  [14:0] i_rx_flags, hv, pv;
    reg  [7:0]  avs_address;
    reg         avs_read, avs_write;
    reg  [31:0] avs_writedata, rnd, ref_crc, exp_crc;
    reg  [31:0] exp_q[$];
    reg  [4:0]  fl;
    wire [31:0] avs_readdata;
    wire        avs_waitrequest, o_anc_sum_replace, o_tx_ffv, o_tx_apv;
    wire [9:0]  o_anc_sum;
    wire [15:0] o_tx_ff_crc, o_tx_ap_crc;
    wire [14:0] o_tx_flags;
    wire        o_packet_absent, o_packet_sum_err, o_flag_lines_oe;
    wire [4:0]  o_flag_lines, ctl_lines, flag_wire;
    wire        i_flag_dir, ctl_oe;
    wire [1:0]  i_flag_sel;
    integer     mismatches = 0;
    integer     cmp_count = 0;
    integer     cyc = 0;
    integer     n, k;
    assign flag_wire = (o_flag_lines_oe && !ctl_oe) ? o_flag_lines
                                                     : ctl_lines;
    edh_core dut (.i_flag_lines(flag_wire), .*);
    edh_flag_ctl fc (.i_clk(i_clk), .i_wire(flag_wire), .o_dir(i_flag_dir),
        .o_sel(i_flag_sel), .o_lines(ctl_lines), .o_lines_oe(ctl_oe));
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    task final_report;
        begin
            $display("compares %0d mismatches %0d", cmp_count, mismatches);
            if (mismatches == 0 && cmp_count > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    task automatic chk(input [31:0] seen, input [31:0] want);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== want) begin
                mismatches = mismatches + 1;
                $display("BAD %0t seen %h want %h", $time, seen, want);
            end
        end
    endtask
    task bus(input wr, input [7:0] a, input [31:0] d);
        begin
            avs_address   <= a;
            avs_writedata <= d;
            avs_read      <= !wr;
            avs_write     <= wr;
            @(posedge i_clk);
            while (avs_waitrequest !== 1'b0) @(posedge i_clk);
            avs_read  <= 1'b0;
            avs_write <= 1'b0;
            @(posedge i_clk);
        end
    endtask
    task rd(input [7:0] a, input [31:0] want);
        begin
            exp_q.push_back(want);
            bus(1'b0, a, 32'h0);
        end
    endtask
    task strobe(input [1:0] which, input [2:0] hpb);
        begin
            {i_pkt_hdr_ok, i_pkt_in_place, i_pkt_sum_bad} <= hpb;
            {i_out_pkt, i_pkt_done} <= which;
            @(posedge i_clk);
            {i_out_pkt, i_pkt_done} <= 2'b00;
            repeat (3) @(posedge i_clk);
            if (which[1])
                chk({o_tx_ff_crc, o_tx_ap_crc}, exp_crc);
        end
    endtask
    task anc(input [9:0] calc);
        begin
            i_anc_sum_calc <= calc;
            anc_go <= 1'b1;
            @(posedge i_clk);
            anc_go <= 1'b0;
            @(posedge i_clk);
            @(negedge i_clk);
            chk({o_anc_sum_replace, o_anc_sum}, {1'b1, calc});
            repeat (3) @(posedge i_clk);
        end
    endtask
    // random stream keeps the crc and checksum paths busy
    always @(posedge i_clk) begin
        rnd = $urandom;
        i_in_data      <= rnd[9:0];
        i_out_data     <= rnd[19:10];
        i_in_word      <= rnd[20] | anc_go;
        i_out_word     <= rnd[21];
        i_ff_region    <= rnd[22];
        i_ap_region    <= rnd[23];
        i_rx_ff_crc    <= rnd[31:16];
        i_rx_ap_crc    <= rnd[15:0];
        i_anc_sum_word <= anc_go;
        i_field_start  <= (rnd[31:26] == 6'h00);
    end
    function [15:0] crc_step(input [15:0] c, input [9:0] d);
        integer j;
        begin
            crc_step = c;
            for (j = 9; j >= 0; j = j - 1)
                crc_step = {crc_step[14:0], 1'b0}
                    ^ ((crc_step[15] ^ d[j]) ? `EDH_CRC_POLY : 16'h0000);
        end
    endfunction
    // reference crcs of the outgoing stream: ff high half, ap low half
    always @(posedge i_clk) begin
        if (i_rst || i_field_start)
            ref_crc <= 32'h0000_0000;
        else
            ref_crc <= {(i_out_word && i_ff_region)
                ? crc_step(ref_crc[31:16], i_out_data) : ref_crc[31:16],
                (i_out_word && i_ap_region)
                ? crc_step(ref_crc[15:0], i_out_data) : ref_crc[15:0]};
        if (i_out_pkt)
            exp_crc <= ref_crc;
    end
    always @(posedge i_clk)
        if (avs_read && avs_waitrequest === 1'b0)
            chk(avs_readdata, exp_q.pop_front());
    always @(posedge i_clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            mismatches = mismatches + 1;
            final_report;
        end
    end
    initial begin
        {i_rx_mode, i_anc_sum_fix_en, anc_go, i_pkt_hdr_ok, i_pkt_in_place,
         i_pkt_done, i_pkt_sum_bad, i_rx_ffv, i_rx_apv, i_out_pkt,
         i_anc_sum_calc, i_rx_flags, avs_address, avs_read, avs_write,
         avs_writedata} = 0;
        i_rst = 1'b1;
        n = $urandom(32'h6A6A);
        repeat (5) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        chk({o_tx_ffv, o_tx_apv}, 2'b11);
        rd(`EDH_REG_CTRL, `EDH_CTRL_RESET);
        rd(`EDH_REG_SENS, {16'h0, `EDH_SENS_RESET});
        rd(8'h40, 32'h0);
        $display("test reset done");
        n = $urandom_range(2, 6);
        bus(1'b1, `EDH_REG_OVR_VAL, 32'h1);
        bus(1'b1, `EDH_REG_OVR_CTL, 32'h1);
        bus(1'b1, `EDH_REG_SENS, 32'hFFFE);
        repeat (n) strobe(2'b10, 3'h0);
        rd(`EDH_REG_CNT, n);
        bus(1'b1, `EDH_REG_SENS, 32'hFFFF);
        strobe(2'b10, 3'h0);
        rd(`EDH_REG_CNT, n);
        bus(1'b1, `EDH_REG_CTRL, {29'h0, `EDH_MODE_AUTO, 1'b0});
        rd(`EDH_REG_CNT_LOW, n);
        rd(`EDH_REG_CNT, 32'h0);
        bus(1'b1, `EDH_REG_SENS, 32'hFFFE);
        strobe(2'b10, 3'h0);
        bus(1'b1, `EDH_REG_CTRL, {29'h0, `EDH_MODE_CLEAR, 1'b0});
        rd(`EDH_REG_CNT, 32'h0);
        rd(`EDH_REG_CTRL, 32'h0);
        strobe(2'b10, 3'h0);
        rd(`EDH_REG_CNT, 32'h1);
        bus(1'b1, `EDH_REG_CTRL, {29'h0, `EDH_MODE_HOLD, 1'b0});
        strobe(2'b10, 3'h0);
        rd(`EDH_REG_CNT, 32'h0);
        bus(1'b1, `EDH_REG_CTRL, 32'h0);
        $display("test counter done");
        hv = $urandom;
        pv = $urandom;
        bus(1'b1, `EDH_REG_OVR_VAL, {15'h0, 2'b11, hv});
        bus(1'b1, `EDH_REG_OVR_CTL, 32'h1FFFF);
        for (k = 0; k < 3; k = k + 1)
            fc.put(k[1:0], pv[k*5 +: 5]);
        fc.put(`EDH_SEL_CTL, 5'h04);
        fc.done_wr;
        strobe(2'b10, 3'h0);
        chk({o_tx_apv, o_tx_ffv, o_tx_flags}, {2'b01, pv});
        strobe(2'b10, 3'h0);
        chk({o_tx_apv, o_tx_ffv, o_tx_flags}, {2'b11, hv});
        for (k = 0; k < 3; k = k + 1) begin
            fc.get(k[1:0], fl);
            chk(fl, hv[k*5 +: 5]);
        end
        fc.get(`EDH_SEL_CTL, fl);
        chk(fl[4], 1'b0);
        $display("test flag port done");
        bus(1'b1, `EDH_REG_OVR_CTL, 32'h0);
        i_rx_mode  <= 1'b1;
        i_rx_flags <= pv & 15'h7DFF;
        i_rx_ffv   <= 1'b1;
        i_rx_apv   <= 1'b0;
        strobe(2'b01, 3'b111);
        rd(`EDH_REG_STATUS, 32'h11);
        strobe(2'b10, 3'h0);
        chk({o_tx_apv, o_tx_flags[9], o_tx_flags[5]}, 3'b110);
        chk(o_tx_flags[14], pv[14]);
        fc.put(`EDH_SEL_CTL, 5'h10);
        fc.done_wr;
        fc.get(`EDH_SEL_AP, fl);
        chk(fl, {1'b0, pv[8:5]});
        fc.get(`EDH_SEL_CTL, fl);
        chk(fl[3:2], 2'b01);
        strobe(2'b01, 3'b010);
        chk(o_packet_absent, 1'b1);
        strobe(2'b10, 3'h0);
        chk({o_tx_flags[14], o_tx_flags[9], o_tx_flags[4]}, 3'b111);
        $display("test receive done");
        i_anc_sum_fix_en <= 1'b1;
        anc(10'h155);
        i_anc_sum_fix_en <= 1'b0;
        bus(1'b1, `EDH_REG_CTRL, 32'h1);
        anc(10'h0AA);
        $display("test checksum done");
        final_report;
    end
endmodule
